// ==== hdl/rx_fifo_ptr_pkg.sv ====
// constants for the receive fifo pointer block: register indices, byte addresses,
// field positions and reset values.
// assumes a 32-bit apb slave with 16-bit byte addresses, one register per word.
`default_nettype none

package rx_fifo_ptr_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int PTR_W = 7;
   localparam int ADDR_W = 16;
   localparam logic [PTR_W-1:0] TOP_LOC = 7'h7f;
   localparam logic [PTR_W-1:0] BELOW_TOP_LOC = 7'h7e;

   // ------------------------------------------------------------
   // register indices (printed offsets) and byte addresses
   // ------------------------------------------------------------
   localparam logic [13:0] IDX_READ_POINTER = 14'h1a50;
   localparam logic [13:0] IDX_READ_AUX = 14'h1a51;
   localparam logic [13:0] IDX_CUR_POINTER = 14'h1a52;
   localparam logic [13:0] IDX_CUR_AUX = 14'h1a53;
   localparam logic [13:0] IDX_HEAD_POINTER = 14'h1a54;
   localparam logic [13:0] IDX_HEAD_AUX = 14'h1a55;
   localparam logic [13:0] IDX_NEXT_POINTER = 14'h1a56;
   localparam logic [13:0] IDX_NEXT_AUX = 14'h1a57;

   localparam logic [ADDR_W-1:0] ADDR_READ_POINTER = {IDX_READ_POINTER, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_READ_AUX = {IDX_READ_AUX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CUR_POINTER = {IDX_CUR_POINTER, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CUR_AUX = {IDX_CUR_AUX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_HEAD_POINTER = {IDX_HEAD_POINTER, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_HEAD_AUX = {IDX_HEAD_AUX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_NEXT_POINTER = {IDX_NEXT_POINTER, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_NEXT_AUX = {IDX_NEXT_AUX, 2'b00};

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int STATE_FLAG_BIT = 7;
   localparam int BELOW_TOP_BIT = 2;
   localparam int AT_TOP_BIT = 1;
   localparam int WRAP_BIT = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [PTR_W-1:0] RST_READ_POINTER = 7'h00;
   localparam logic [PTR_W-1:0] RST_CUR_POINTER = 7'h00;
   localparam logic [PTR_W-1:0] RST_HEAD_POINTER = 7'h00;
   localparam logic [PTR_W-1:0] RST_NEXT_POINTER = 7'h01;
   localparam logic RST_WRAP = 1'b0;
   localparam logic RST_EMPTY = 1'b1;
   localparam logic RST_FULL = 1'b0;
   localparam logic RST_NO_ROOM = 1'b0;

endpackage : rx_fifo_ptr_pkg

`default_nettype wire

// ==== hdl/ring_step.sv ====
// one step of a ring pointer: location plus one modulo the ram size, and the
// wrap bit toggled when the step leaves the top location.
// assumes a power-of-two ram; purely combinational.
`default_nettype none

module ring_step #(
   parameter int PTR_W = 7
) (
   input wire logic [PTR_W-1:0] ptr,      // present location
   input wire logic wrap,                 // present wrap bit
   output logic [PTR_W-1:0] ptr_inc,      // location after one step
   output logic wrap_inc                  // wrap bit after one step
);

   assign ptr_inc = ptr + 1'b1;           // R21
   assign wrap_inc = wrap ^ (&ptr);       // R21

endmodule : ring_step

`default_nettype wire

// ==== hdl/pd_rx_fifo_pointers.sv ====
// pointer and flag logic of the receive fifo of a power delivery mac, with an apb
// register slave. the ram itself lives outside; this block only hands out addresses.
// assumes push, pop, commit and drop strobes come from logic on pclk (no sync).
//
// Notes on behaviour
// R1: empty flag is high while packet start equals read position; resets high.
// R2: read-only flag shows the read pointer at location 127.
// R3: read wrap bit toggles whenever the read pointer steps past 127.
// R4: software moving the read pointer across the top must toggle its wrap bit.
// R5: software rewriting the read pointer keeps its aux bits consistent.
// R6: 7-bit byte write pointer, reset zero, addresses the next received byte.
// R7: full flag is high while byte write position meets read position.
// R8: read-only flag shows the byte write pointer at location 127.
// R9: byte write wrap bit toggles when that pointer steps past 127.
// R10: 7-bit packet start pointer, reset zero, marks the next packet start.
// R11: header room lacking when start or start-plus-one meets the read position.
// R12: read-only flag shows the packet start pointer at location 126.
// R13: read-only flag shows the packet start pointer at location 127.
// R14: packet start wrap bit toggles when that pointer passes 127.
// R15: 7-bit start-plus-one pointer, reset one, follows the packet start.
// R16: write-side pointers are written only while idle, kept mutually consistent.
// R17: write-side pointer registers are debug aids, normally left alone.
// R18: read pointer writes wait in a holding register until aux bits are written.
// R19: read pointer is 7 bits, software writable, reset zero.
// R20: start-plus-one wrap bit is writable and toggles past 127.
// R21: pointers advance modulo 128; pointer plus wrap bit is an 8-bit position.
//
// Register access over APB was chosen for this implementation.
`default_nettype none

module pd_rx_fifo_pointers
   import rx_fifo_ptr_pkg::*;
(
   input wire logic pclk,                       // apb clock, 25 mhz
   input wire logic presetn,                    // async reset, active low
   input wire logic psel,                       // apb select
   input wire logic penable,                    // apb access phase
   input wire logic pwrite,                     // apb direction, high for write
   input wire logic [ADDR_W-1:0] paddr,         // apb byte address
   input wire logic [31:0] pwdata,              // apb write data
   output logic [31:0] prdata,                  // apb read data
   output logic pready,                         // apb ready
   output logic pslverr,                        // apb error, unmapped address
   input wire logic push_byte,                  // mac stores a byte at the write pointer
   input wire logic pop_byte,                   // consumer takes the byte at read pointer
   input wire logic packet_commit,              // mac accepts the packet just written
   input wire logic packet_drop,                // mac discards the packet just written
   output logic [PTR_W-1:0] rx_byte_write_pointer, // ram address for the next byte
   output logic [PTR_W-1:0] rx_read_pointer,    // ram address of the next byte to read
   output logic fifo_empty,                     // no committed data
   output logic fifo_full,                      // byte write pointer has caught up
   output logic header_space_lacking_flag       // no room for status and length
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [PTR_W-1:0] read_hold;
      logic [PTR_W-1:0] read_ptr;
      logic read_wrap;
      logic [PTR_W-1:0] cur_ptr;
      logic cur_wrap;
      logic [PTR_W-1:0] head_ptr;
      logic head_wrap;
      logic [PTR_W-1:0] next_ptr;
      logic next_wrap;
      logic empty;
      logic full;
      logic no_room;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } state_type;

   state_type s;
   state_type next_s;

   // ------------------------------------------------------------
   // pointer steps, read side and byte write side
   // ------------------------------------------------------------
   logic [PTR_W-1:0] step_in [2];
   logic step_wrap_in [2];
   logic [PTR_W-1:0] step_out [2];
   logic step_wrap_out [2];

   assign step_in[0] = s.read_ptr;
   assign step_wrap_in[0] = s.read_wrap;
   assign step_in[1] = s.cur_ptr;
   assign step_wrap_in[1] = s.cur_wrap;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_step
         ring_step #(
            .PTR_W(PTR_W)
         ) u_step (
            .ptr(step_in[g]),
            .wrap(step_wrap_in[g]),
            .ptr_inc(step_out[g]),
            .wrap_inc(step_wrap_out[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // register read view
   // ------------------------------------------------------------
   logic [7:0] read_aux_view;
   logic [7:0] cur_aux_view;
   logic [7:0] head_aux_view;

   always_comb begin
      read_aux_view = 8'h00;
      read_aux_view[STATE_FLAG_BIT] = s.empty;                    // R1
      read_aux_view[AT_TOP_BIT] = (s.read_ptr == TOP_LOC);        // R2
      read_aux_view[WRAP_BIT] = s.read_wrap;
      cur_aux_view = 8'h00;
      cur_aux_view[STATE_FLAG_BIT] = s.full;                      // R7
      cur_aux_view[AT_TOP_BIT] = (s.cur_ptr == TOP_LOC);          // R8
      cur_aux_view[WRAP_BIT] = s.cur_wrap;
      head_aux_view = 8'h00;
      head_aux_view[STATE_FLAG_BIT] = s.no_room;                  // R11
      head_aux_view[BELOW_TOP_BIT] = (s.head_ptr == BELOW_TOP_LOC); // R12
      head_aux_view[AT_TOP_BIT] = (s.head_ptr == TOP_LOC);        // R13
      head_aux_view[WRAP_BIT] = s.head_wrap;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic access;
   logic write_done;
   logic hit;
   logic [7:0] rbyte;

   always_comb begin
      next_s = s;
      next_s.ready = 1'b0;
      next_s.slverr = 1'b0;
      // one wait state: the answer is registered so every output comes from a flop
      access = psel & penable & ~s.ready;
      write_done = psel & penable & s.ready & pwrite & ~s.slverr;
      hit = 1'b1;
      rbyte = 8'h00;

      unique case (paddr)
         ADDR_READ_POINTER: rbyte = {1'b0, s.read_ptr};
         ADDR_READ_AUX: rbyte = read_aux_view;
         ADDR_CUR_POINTER: rbyte = {1'b0, s.cur_ptr};
         ADDR_CUR_AUX: rbyte = cur_aux_view;
         ADDR_HEAD_POINTER: rbyte = {1'b0, s.head_ptr};
         ADDR_HEAD_AUX: rbyte = head_aux_view;
         ADDR_NEXT_POINTER: rbyte = {1'b0, s.next_ptr};
         ADDR_NEXT_AUX: rbyte = {7'h00, s.next_wrap};
         default: hit = 1'b0;
      endcase

      if (access) begin
         next_s.ready = 1'b1;
         next_s.slverr = ~hit;
         next_s.rdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
      end

      // software writes land at the edge where pready is sampled high
      if (write_done) begin
         unique case (paddr)
            ADDR_READ_POINTER: next_s.read_hold = pwdata[PTR_W-1:0]; // R18
            ADDR_READ_AUX: begin
               next_s.read_ptr = s.read_hold;                   // R18 R19
               next_s.read_wrap = pwdata[WRAP_BIT];             // R4 R5
            end
            ADDR_CUR_POINTER: next_s.cur_ptr = pwdata[PTR_W-1:0];   // R16
            ADDR_CUR_AUX: next_s.cur_wrap = pwdata[WRAP_BIT];
            ADDR_HEAD_POINTER: next_s.head_ptr = pwdata[PTR_W-1:0]; // R16
            ADDR_HEAD_AUX: next_s.head_wrap = pwdata[WRAP_BIT];
            ADDR_NEXT_POINTER: next_s.next_ptr = pwdata[PTR_W-1:0];
            ADDR_NEXT_AUX: next_s.next_wrap = pwdata[WRAP_BIT];     // R20
            default: ;
         endcase
      end

      // hardware events come after software writes, so a clash favours hardware
      if (pop_byte && !s.empty) begin
         next_s.read_ptr = step_out[0];                       // R3
         next_s.read_wrap = step_wrap_out[0];                 // R3
      end
      if (packet_drop && !packet_commit) begin
         next_s.cur_ptr = s.head_ptr;
         next_s.cur_wrap = s.head_wrap;
      end else if (packet_commit) begin
         // start moves to the byte pointer; its wrap follows, i.e. toggles past 127
         next_s.head_ptr = s.cur_ptr;                         // R10 R14
         next_s.head_wrap = s.cur_wrap;                       // R14
         next_s.next_ptr = step_out[1];                       // R15
         next_s.next_wrap = step_wrap_out[1];                 // R20
      end
      if (push_byte && !s.full && !packet_drop) begin
         next_s.cur_ptr = step_out[1];                        // R6 R9
         next_s.cur_wrap = step_wrap_out[1];                  // R9
      end

      // flags follow the next pointers so they are valid with them, not a cycle late
      next_s.empty = ({next_s.head_wrap, next_s.head_ptr}
                      == {next_s.read_wrap, next_s.read_ptr});        // R1 R21
      next_s.full = ({~next_s.cur_wrap, next_s.cur_ptr}
                     == {next_s.read_wrap, next_s.read_ptr});          // R7 R21
      next_s.no_room = ({~next_s.head_wrap, next_s.head_ptr}
                        == {next_s.read_wrap, next_s.read_ptr})
                     | ({~next_s.next_wrap, next_s.next_ptr}
                        == {next_s.read_wrap, next_s.read_ptr});       // R11
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.read_hold <= RST_READ_POINTER;
         s.read_ptr <= RST_READ_POINTER;                      // R19
         s.read_wrap <= RST_WRAP;
         s.cur_ptr <= RST_CUR_POINTER;                        // R6
         s.cur_wrap <= RST_WRAP;
         s.head_ptr <= RST_HEAD_POINTER;                      // R10
         s.head_wrap <= RST_WRAP;
         s.next_ptr <= RST_NEXT_POINTER;                      // R15
         s.next_wrap <= RST_WRAP;
         s.empty <= RST_EMPTY;                                // R1
         s.full <= RST_FULL;
         s.no_room <= RST_NO_ROOM;
         s.ready <= 1'b0;
         s.slverr <= 1'b0;
         s.rdata <= 32'h0000_0000;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.slverr;
   assign rx_byte_write_pointer = s.cur_ptr;
   assign rx_read_pointer = s.read_ptr;
   assign fifo_empty = s.empty;
   assign fifo_full = s.full;
   assign header_space_lacking_flag = s.no_room;

endmodule : pd_rx_fifo_pointers

`default_nettype wire

// ==== tb/pd_rx_fifo_pointers_sva.sv ====
// checker for the rx fifo pointer block: apb timing and pointer motion.
// assumes it is bound to the block's top module and sees only its ports.
`default_nettype none

module pd_rx_fifo_pointers_chk
   import rx_fifo_ptr_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic push_byte, // byte strobe
   input wire logic pop_byte, // pop strobe
   input wire logic packet_commit, // keep packet
   input wire logic packet_drop, // discard packet
   input wire logic [PTR_W-1:0] rx_byte_write_pointer, // byte pointer
   input wire logic [PTR_W-1:0] rx_read_pointer, // read pointer
   input wire logic fifo_empty, // empty flag
   input wire logic fifo_full, // full flag
   input wire logic header_space_lacking_flag // header room flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rdy_one; psel && penable && !pready |=> pready; endproperty
   property p_rdy_pulse; pready |=> !pready; endproperty
   property p_err_rdy; pslverr |-> pready && psel && penable; endproperty
   property p_reset;
      $rose(presetn) |-> rx_byte_write_pointer == 7'h00 && rx_read_pointer == 7'h00
         && fifo_empty && !fifo_full;
   endproperty
   property p_push;
      push_byte && !fifo_full && !packet_drop && !psel
         |=> rx_byte_write_pointer == $past(rx_byte_write_pointer) + 7'h01;
   endproperty
   property p_pop;
      pop_byte && !fifo_empty && !psel |=> rx_read_pointer == $past(rx_read_pointer) + 7'h01;
   endproperty
   property p_full_eq; fifo_full |-> rx_byte_write_pointer == rx_read_pointer; endproperty
   property p_full_hold;
      fifo_full && !packet_drop && !psel |=> $stable(rx_byte_write_pointer);
   endproperty
   property p_empty_hold; fifo_empty && !packet_commit && !psel |=> fifo_empty; endproperty
   // a pointer write alone must not move the live read pointer
   property p_hold_reg;
      psel && penable && pready && pwrite && paddr == ADDR_READ_POINTER && !pop_byte
         |=> $stable(rx_read_pointer);
   endproperty

   a_rdy_one: assert property (p_rdy_one) else $error("pready late");
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   a_reset: assert property (p_reset) else $error("bad reset state");
   a_push: assert property (p_push) else $error("byte pointer step");
   a_pop: assert property (p_pop) else $error("read pointer step");
   a_full_eq: assert property (p_full_eq) else $error("full with unequal pointers");
   a_full_hold: assert property (p_full_hold) else $error("push while full");
   a_empty_hold: assert property (p_empty_hold) else $error("empty lost");
   a_hold_reg: assert property (p_hold_reg) else $error("read pointer not held");

   c_full: cover property (fifo_full && push_byte);
   c_lack: cover property (header_space_lacking_flag);
   c_err: cover property (pslverr);
endmodule : pd_rx_fifo_pointers_chk

`default_nettype wire

// ==== tb/rx_mac_model.sv ====
// model of the mac receive path: pushes bytes, then commits or drops a packet.
// assumes the bench calls its tasks between register accesses only.
`default_nettype none

module rx_mac_model (
   input wire logic pclk, // block clock
   output var logic push_byte, // byte strobe
   output var logic packet_commit, // keep packet
   output var logic packet_drop // discard packet
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      push_byte = 1'b0;
      packet_commit = 1'b0;
      packet_drop = 1'b0;
   end

   // strobes move only right after an edge and never during pointer writes
   task push(input int n);
      repeat (n) begin
         @(posedge pclk);
         push_byte <= 1'b1;
      end
      @(posedge pclk);
      push_byte <= 1'b0;
   endtask : push

   task end_pkt(input logic keep);
      packet_commit <= keep;
      packet_drop <= !keep;
      @(posedge pclk);
      packet_commit <= 1'b0;
      packet_drop <= 1'b0;
   endtask : end_pkt
endmodule : rx_mac_model

`default_nettype wire

// ==== tb/pd_rx_fifo_pointers_tb_top.sv ====
// bench for the rx fifo pointer block: apb register access plus mac strobes.
// assumes the checker and the mac model are compiled before this file.
`default_nettype none
`define CHK(nm, x, g) begin n_checks++; if ((g) !== (x)) begin error_cnt++; \
   $display("[FAIL] %s exp %h got %h", nm, x, g); end end

module pd_rx_fifo_pointers_tb_top
   import rx_fifo_ptr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic pop_byte;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata, q;
   logic pready, pslverr, push_byte, packet_commit, packet_drop, e;
   logic fifo_empty, fifo_full, header_space_lacking_flag;
   logic [PTR_W-1:0] rx_byte_write_pointer, rx_read_pointer;
   int error_cnt;
   int n_checks;

   pd_rx_fifo_pointers i_pd_rx_fifo_pointers (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .push_byte, .pop_byte, .packet_commit,
      .packet_drop, .rx_byte_write_pointer, .rx_read_pointer, .fifo_empty, .fifo_full,
      .header_space_lacking_flag);
   rx_mac_model i_mac (.pclk, .push_byte, .packet_commit, .packet_drop);

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 16) begin
         error_cnt++;
         end_sim;
      end
   endtask : apb

   task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rd(input logic [ADDR_W-1:0] a, input logic [7:0] x, input string nm);
      apb(1'b0, a, 8'h00);
      `CHK(nm, {24'h0, x}, q)
   endtask : rd

   task pops(input int n);
      repeat (n) begin
         @(posedge pclk);
         pop_byte <= 1'b1;
      end
      @(posedge pclk);
      pop_byte <= 1'b0;
   endtask : pops

   task t_reset;
      logic [7:0] tab [8];
      tab = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
      for (int i = 0; i < 8; i++) rd(ADDR_READ_POINTER + 16'(4 * i), tab[i], "reset");
      rd(16'h6960, 8'h00, "unmapped data");
      `CHK("unmapped err", 1'b1, e)
      pops(1);
      rd(ADDR_READ_POINTER, 8'h00, "pop when empty");
      $display("test reset done");
   endtask : t_reset

   task t_packet;
      i_mac.push(3);
      i_mac.end_pkt(1'b1);
      @(negedge pclk);
      `CHK("empty after commit", 1'b0, fifo_empty)
      i_mac.push(2);
      i_mac.end_pkt(1'b0);
      rd(ADDR_CUR_POINTER, 8'h03, "drop restores");
      rd(ADDR_HEAD_POINTER, 8'h03, "start");
      rd(ADDR_NEXT_POINTER, 8'h04, "start plus one");
      pops(4);
      @(negedge pclk);
      `CHK("read ptr port", 7'h03, rx_read_pointer)
      rd(ADDR_READ_POINTER, 8'h03, "read pointer");
      rd(ADDR_READ_AUX, 8'h80, "empty again");
      $display("test packet done");
   endtask : t_packet

   task t_wrap;
      wr(ADDR_CUR_POINTER, 8'h7e);
      wr(ADDR_HEAD_POINTER, 8'h7f);
      wr(ADDR_NEXT_POINTER, 8'h7f);
      rd(ADDR_HEAD_AUX, 8'h02, "start at top");
      wr(ADDR_HEAD_POINTER, 8'h7e);
      wr(ADDR_READ_POINTER, 8'h7e);
      rd(ADDR_READ_POINTER, 8'h03, "held write");
      wr(ADDR_READ_AUX, 8'h00);
      rd(ADDR_READ_POINTER, 8'h7e, "transferred");
      rd(ADDR_HEAD_AUX, 8'h04, "start below top");
      i_mac.push(1);
      rd(ADDR_CUR_AUX, 8'h02, "byte at top");
      i_mac.push(1);
      rd(ADDR_CUR_AUX, 8'h01, "byte wrapped");
      i_mac.end_pkt(1'b1);
      rd(ADDR_HEAD_AUX, 8'h01, "start wrapped");
      rd(ADDR_NEXT_AUX, 8'h01, "next wrapped");
      pops(1);
      rd(ADDR_READ_AUX, 8'h02, "read at top");
      pops(1);
      rd(ADDR_READ_AUX, 8'h81, "read wrapped");
      $display("test wrap done");
   endtask : t_wrap

   task t_full;
      i_mac.push(128);
      @(negedge pclk);
      `CHK("full port", 1'b1, fifo_full)
      `CHK("byte ptr port", 7'h00, rx_byte_write_pointer)
      i_mac.push(1);
      rd(ADDR_CUR_POINTER, 8'h00, "push when full");
      rd(ADDR_CUR_AUX, 8'h80, "full flag");
      i_mac.end_pkt(1'b1);
      @(negedge pclk);
      `CHK("lacking port", 1'b1, header_space_lacking_flag)
      rd(ADDR_HEAD_AUX, 8'h80, "lacking flag");
      // software flushes a whole ram pass: same location, so it toggles the wrap bit itself
      wr(ADDR_READ_POINTER, 8'h00);
      wr(ADDR_READ_AUX, 8'h00);
      rd(ADDR_READ_AUX, 8'h80, "flushed empty");
      rd(ADDR_CUR_AUX, 8'h00, "full cleared");
      rd(ADDR_HEAD_AUX, 8'h00, "room again");
      $display("test full done");
   endtask : t_full

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pop_byte = 1'b0;
      paddr = '0;
      pwdata = '0;
      error_cnt = 0;
      n_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_packet;
      t_wrap;
      t_full;
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_sim;
   end
endmodule : pd_rx_fifo_pointers_tb_top

bind pd_rx_fifo_pointers pd_rx_fifo_pointers_chk i_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .push_byte, .pop_byte, .packet_commit,
   .packet_drop, .rx_byte_write_pointer, .rx_read_pointer, .fifo_empty, .fifo_full,
   .header_space_lacking_flag);

`default_nettype wire
